// ==== hw/sig_mask.sv ====
// fault and warning indication source masking with apb registers
`timescale 1ns/1ps
// Behaviour
// [R1] with live fault bit 6 set the fault output follows the warning.
// [R2] with live fault bit 5 set a live clock-invalid flag raises fault.
// [R3] with live fault bit 4 set any live thermal shutdown raises fault.
// [R4] with live fault bit 3 set any live supply flag raises fault.
// [R5] with live fault bit 0 set any unfinished load diagnostic faults.
// [R6] with stored warn bit 6 set any latched clip flag raises warning.
// [R7] with stored warn bit 5 set latched clock-invalid raises warning.
// [R8] with stored warn bit 4 set latched thermal shutdown warns.
// [R9] with stored warn bit 3 set any latched supply flag warns.
// [R10] stored warn bit 2 enables latched over-temp warning, reset one.
// [R11] with stored warn bit 1 set latched gain foldback warns.
// [R12] with stored warn bit 0 set latched current limit warns.
// [R13] stored fault bit 6 faults on any channel state code 101.
// [R14] each output is the or of its enabled terms, idle with none.
// [R15] reserved mask bits do nothing and reset to zero.
module sig_mask
  import sig_mask_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_nrst,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic                   o_pready,
  output logic                   o_pslverr,
  output logic [31:0]            o_prdata,
  input  wire live_flags_t       i_live,
  input  wire latched_flags_t    i_latched,
  input  wire state_reports_t    i_state_report,
  output logic                   o_fault,
  output logic                   o_warn,
  output logic                   o_irq
);

  logic [7:0]  fault_stored_reg;
  logic [7:0]  fault_live_reg;
  logic [7:0]  warn_stored_reg;
  logic [1:0]  irq_status_reg;
  logic [1:0]  irq_enable_reg;
  logic        fault_reg;
  logic        warn_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;

  // bus decode
  wire [ADDR_W-3:0] word_idx = i_paddr[ADDR_W-1:2];
  wire        setup_ph   = i_psel && !i_penable;
  wire        wr_go      = i_psel && i_penable && i_pwrite && o_pready;
  wire        lane0      = i_pstrb[0];
  wire        hit_fs     = word_idx == FAULT_STORED_IDX[ADDR_W-3:0];
  wire        hit_fl     = word_idx == FAULT_LIVE_IDX[ADDR_W-3:0];
  wire        hit_ws     = word_idx == WARN_STORED_IDX[ADDR_W-3:0];
  wire        hit_st     = word_idx == IRQ_STATUS_IDX[ADDR_W-3:0];
  wire        hit_en     = word_idx == IRQ_ENABLE_IDX[ADDR_W-3:0];
  wire        hit_cl     = word_idx == IRQ_CLEAR_IDX[ADDR_W-3:0];
  wire        hit_any    = hit_fs || hit_fl || hit_ws || hit_st ||
                           hit_en || hit_cl;
  wire        ro_bad     = hit_st && i_pwrite;
  wire        wo_bad     = hit_cl && !i_pwrite;
  wire        bad_next   = !hit_any || ro_bad || wo_bad;
  wire        wr_fs      = wr_go && hit_fs && lane0;
  wire        wr_fl      = wr_go && hit_fl && lane0;
  wire        wr_ws      = wr_go && hit_ws && lane0;
  wire        wr_en      = wr_go && hit_en && lane0;
  wire        wr_cl      = wr_go && hit_cl && lane0;
  wire [7:0]  wbyte      = i_pwdata[7:0];

  wire [31:0] rd_fs = {24'h00_0000, fault_stored_reg};
  wire [31:0] rd_fl = {24'h00_0000, fault_live_reg};
  wire [31:0] rd_ws = {24'h00_0000, warn_stored_reg};
  wire [31:0] rd_st = {30'h0000_0000, irq_status_reg};
  wire [31:0] rd_en = {30'h0000_0000, irq_enable_reg};
  wire [31:0] rdata_next = hit_fs ? rd_fs :
                           hit_fl ? rd_fl :
                           hit_ws ? rd_ws :
                           hit_st ? rd_st :
                           hit_en ? rd_en : 32'h0000_0000;

  // live fault source terms
  wire live_therm  = |i_live.thermal_shutdown_flag ||
                     i_live.thermal_shutdown_global;
  wire live_supply = i_live.battery_undervoltage_flag ||
                     i_live.battery_overvoltage_flag ||
                     i_live.stage_supply_undervoltage_flag ||
                     i_live.stage_supply_overvoltage_flag ||
                     i_live.gate_supply_fault_flag;
  wire live_diag   = !(&i_live.load_diag_done_report);

  // latched warning source terms
  wire lat_clip    = |i_latched.clip_flag;
  wire lat_therm   = |i_latched.thermal_shutdown_flag ||
                     i_latched.thermal_shutdown_global;
  wire lat_supply  = i_latched.battery_undervoltage_flag ||
                     i_latched.battery_overvoltage_flag ||
                     i_latched.stage_supply_undervoltage_flag ||
                     i_latched.stage_supply_overvoltage_flag ||
                     i_latched.logic_supply_por_flag ||
                     i_latched.gate_supply_fault_flag;
  wire lat_otw     = |i_latched.overtemp_warning_flag ||
                     i_latched.overtemp_warning_global;
  wire lat_ilim    = |i_latched.current_limit_warn_flag;

  logic prot_shutdn;
  always_comb begin
    prot_shutdn = 1'b0;
    for (int ch = 0; ch < 4; ch++) begin
      if (i_state_report[ch] == PROT_SHUTDOWN_CODE) begin
        prot_shutdn = 1'b1; // see [R13]
      end
    end
  end

  // warning: or of enabled latched terms
  wire w_clip  = warn_stored_reg[WS_CLIP] && lat_clip;           // see [R6]
  wire w_clk   = warn_stored_reg[WS_CLOCK_BAD] &&
                 i_latched.clock_invalid_flag;                   // see [R7]
  wire w_therm = warn_stored_reg[WS_THERMAL] && lat_therm;       // see [R8]
  wire w_sup   = warn_stored_reg[WS_SUPPLY] && lat_supply;       // see [R9]
  wire w_otw   = warn_stored_reg[WS_OVERTEMP] && lat_otw;        // see [R10]
  wire w_fold  = warn_stored_reg[WS_FOLDBACK] &&
                 i_latched.gain_foldback_warning;                // see [R11]
  wire w_ilim  = warn_stored_reg[WS_CUR_LIMIT] && lat_ilim;      // see [R12]
  wire warn_next = w_clip || w_clk || w_therm || w_sup ||
                   w_otw || w_fold || w_ilim;                    // see [R14]

  // fault: or of enabled live terms, stored terms and warning
  wire f_warn  = fault_live_reg[FL_ON_WARN] && warn_next;        // see [R1]
  wire f_clk   = fault_live_reg[FL_CLOCK_BAD] &&
                 i_live.clock_invalid_flag;                      // see [R2]
  wire f_therm = fault_live_reg[FL_THERMAL] && live_therm;       // see [R3]
  wire f_sup   = fault_live_reg[FL_SUPPLY] && live_supply;       // see [R4]
  wire f_diag  = fault_live_reg[FL_DIAG] && live_diag;           // see [R5]
  wire f_prot  = fault_stored_reg[FS_PROT_SHUTDN] && prot_shutdn; // see [R13]
  wire fault_next = f_warn || f_clk || f_therm || f_sup ||
                    f_diag || f_prot;                            // see [R14]

  // interrupt events on rising indication edges; set beats clear
  wire [1:0] irq_evt;
  assign irq_evt[IRQ_FAULT_BIT] = fault_next && !fault_reg;
  assign irq_evt[IRQ_WARN_BIT]  = warn_next && !warn_reg;
  wire [1:0] irq_clr    = wr_cl ? wbyte[1:0] : 2'b00;
  wire [1:0] irq_status_next = (irq_status_reg & ~irq_clr) | irq_evt;

  assign o_pready  = 1'b1;
  assign o_pslverr = pslverr_reg;
  assign o_prdata  = prdata_reg;
  assign o_fault   = fault_reg;
  assign o_warn    = warn_reg;
  assign o_irq     = |(irq_status_reg & irq_enable_reg);

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      fault_stored_reg <= FAULT_STORED_RST;
      fault_live_reg   <= FAULT_LIVE_RST;
      warn_stored_reg  <= WARN_STORED_RST;              // see [R10]
    end else begin
      if (wr_fs) begin
        fault_stored_reg <= wbyte & FAULT_STORED_WMSK;  // see [R15]
      end
      if (wr_fl) begin
        fault_live_reg <= wbyte & FAULT_LIVE_WMSK;      // see [R15]
      end
      if (wr_ws) begin
        warn_stored_reg <= wbyte & WARN_STORED_WMSK;    // see [R15]
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_status_reg <= 2'b00;
      irq_enable_reg <= 2'b00;
    end else begin
      irq_status_reg <= irq_status_next;
      if (wr_en) begin
        irq_enable_reg <= wbyte[1:0];
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      fault_reg <= 1'b0;
      warn_reg  <= 1'b0;
    end else begin
      fault_reg <= fault_next;
      warn_reg  <= warn_next;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup_ph) begin
      prdata_reg  <= i_pwrite ? 32'h0000_0000 : rdata_next;
      pslverr_reg <= bad_next;
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  sequence warn_rise_s;
    warn_next && !warn_reg;
  endsequence

  sequence warn_flag_s;
    irq_status_reg[IRQ_WARN_BIT] ##0 o_warn;
  endsequence

  fault_on_warn_a: assert property ( // see [R1]
    fault_live_reg[FL_ON_WARN] && warn_next |=> o_fault && o_warn)
    else $error("fault did not follow warning");
  warn_isolated_a: assert property ( // see [R1]
    fault_live_reg == 8'h40 && fault_stored_reg == 8'h00 && !warn_next
    |=> !o_fault)
    else $error("fault raised without warning");
  clk_fault_a: assert property ( // see [R2]
    fault_live_reg[FL_CLOCK_BAD] && i_live.clock_invalid_flag |=> o_fault)
    else $error("clock invalid did not raise fault");
  therm_fault_a: assert property ( // see [R3]
    fault_live_reg[FL_THERMAL] && i_live.thermal_shutdown_flag[3]
    |=> o_fault)
    else $error("thermal shutdown did not raise fault");
  supply_fault_a: assert property ( // see [R4]
    fault_live_reg[FL_SUPPLY] && i_live.gate_supply_fault_flag |=> o_fault)
    else $error("supply flag did not raise fault");
  diag_fault_a: assert property ( // see [R5]
    fault_live_reg[FL_DIAG] && !i_live.load_diag_done_report[0]
    |=> o_fault)
    else $error("unfinished diagnostic did not raise fault");
  clip_warn_a: assert property ( // see [R6]
    warn_stored_reg[WS_CLIP] && i_latched.clip_flag[2] |=> o_warn)
    else $error("clip did not raise warning");
  clk_warn_a: assert property ( // see [R7]
    warn_stored_reg[WS_CLOCK_BAD] && i_latched.clock_invalid_flag
    |=> o_warn)
    else $error("latched clock invalid did not warn");
  therm_warn_a: assert property ( // see [R8]
    warn_stored_reg[WS_THERMAL] && i_latched.thermal_shutdown_global
    |=> o_warn)
    else $error("latched thermal shutdown did not warn");
  supply_warn_a: assert property ( // see [R9]
    warn_stored_reg[WS_SUPPLY] && i_latched.logic_supply_por_flag
    |=> o_warn)
    else $error("latched supply flag did not warn");
  otw_warn_a: assert property ( // see [R10]
    warn_stored_reg[WS_OVERTEMP] && i_latched.overtemp_warning_global
    |=> o_warn)
    else $error("latched over-temp did not warn");
  otw_reset_a: assert property ( // see [R10]
    $rose(i_nrst) |-> warn_stored_reg == WARN_STORED_RST)
    else $error("warning mask reset value wrong");
  fold_warn_a: assert property ( // see [R11]
    warn_stored_reg[WS_FOLDBACK] && i_latched.gain_foldback_warning
    |=> o_warn)
    else $error("foldback did not warn");
  ilim_warn_a: assert property ( // see [R12]
    warn_stored_reg[WS_CUR_LIMIT] && i_latched.current_limit_warn_flag[1]
    |=> o_warn)
    else $error("current limit did not warn");
  prot_fault_a: assert property ( // see [R13]
    fault_stored_reg[FS_PROT_SHUTDN] && i_state_report[2] == 3'h5
    |=> o_fault)
    else $error("protective shutdown did not raise fault");
  all_quiet_a: assert property ( // see [R14]
    fault_live_reg == 8'h00 && fault_stored_reg == 8'h00 &&
    warn_stored_reg == 8'h00 |=> !o_fault && !o_warn)
    else $error("indication active with masks cleared");
  reserved_zero_a: assert property ( // see [R15]
    !fault_live_reg[7] && !fault_live_reg[2] && !fault_live_reg[1] &&
    !warn_stored_reg[7] && !fault_stored_reg[7])
    else $error("reserved mask bit set");
  warn_irq_a: assert property (
    warn_rise_s |=> warn_flag_s)
    else $error("warning edge did not set status");
  irq_level_a: assert property (
    irq_status_reg[IRQ_WARN_BIT] && irq_enable_reg[IRQ_WARN_BIT] |-> o_irq)
    else $error("enabled status did not raise interrupt");
  fault_irq_a: assert property (
    fault_next && !fault_reg |=> irq_status_reg[IRQ_FAULT_BIT] && o_fault)
    else $error("fault edge did not set status");
  irq_clear_a: assert property (
    wr_cl && wbyte[IRQ_WARN_BIT] && !irq_evt[IRQ_WARN_BIT]
    |=> !irq_status_reg[IRQ_WARN_BIT])
    else $error("warning status not cleared");
  warn_idle_a: assert property ( // see [R14]
    warn_stored_reg == 8'h00 |=> !o_warn)
    else $error("warning active with its mask cleared");
  fault_idle_a: assert property ( // see [R14]
    fault_live_reg == 8'h00 && !fault_stored_reg[FS_PROT_SHUTDN]
    |=> !o_fault)
    else $error("fault active with its masks cleared");
  prot_idle_a: assert property ( // see [R13]
    fault_stored_reg[FS_PROT_SHUTDN] && fault_live_reg == 8'h00 &&
    !prot_shutdn |=> !o_fault)
    else $error("fault raised without protective shutdown");
  bus_error_a: assert property (
    setup_ph && !hit_any |=> o_pslverr)
    else $error("unmapped access gave no error");

endmodule

// ==== shared/sig_mask_pkg.sv ====
// constants and types for the fault and warning source masking block
package sig_mask_pkg;
  // register indices; the byte address is four times the index
  localparam logic [7:0] FAULT_STORED_IDX  = 8'h1d;
  localparam logic [7:0] FAULT_LIVE_IDX    = 8'h1e;
  localparam logic [7:0] WARN_STORED_IDX   = 8'h1f;
  localparam logic [7:0] IRQ_STATUS_IDX    = 8'h30;
  localparam logic [7:0] IRQ_ENABLE_IDX    = 8'h31;
  localparam logic [7:0] IRQ_CLEAR_IDX     = 8'h32;
  // reset values and writable-bit masks
  localparam logic [7:0] FAULT_STORED_RST  = 8'h17;
  localparam logic [7:0] FAULT_LIVE_RST    = 8'h00;
  localparam logic [7:0] WARN_STORED_RST   = 8'h04;
  localparam logic [7:0] FAULT_STORED_WMSK = 8'h7f;
  localparam logic [7:0] FAULT_LIVE_WMSK   = 8'h79;
  localparam logic [7:0] WARN_STORED_WMSK  = 8'h7f;
  // field positions
  localparam int FL_ON_WARN      = 6;
  localparam int FL_CLOCK_BAD    = 5;
  localparam int FL_THERMAL      = 4;
  localparam int FL_SUPPLY       = 3;
  localparam int FL_DIAG         = 0;
  localparam int WS_CLIP         = 6;
  localparam int WS_CLOCK_BAD    = 5;
  localparam int WS_THERMAL      = 4;
  localparam int WS_SUPPLY       = 3;
  localparam int WS_OVERTEMP     = 2;
  localparam int WS_FOLDBACK     = 1;
  localparam int WS_CUR_LIMIT    = 0;
  localparam int FS_PROT_SHUTDN  = 6;
  localparam int IRQ_FAULT_BIT   = 0;
  localparam int IRQ_WARN_BIT    = 1;
  localparam logic [2:0] PROT_SHUTDOWN_CODE = 3'h5;

  typedef struct packed {
    logic       clock_invalid_flag;
    logic [3:0] thermal_shutdown_flag;
    logic       thermal_shutdown_global;
    logic       battery_undervoltage_flag;
    logic       battery_overvoltage_flag;
    logic       stage_supply_undervoltage_flag;
    logic       stage_supply_overvoltage_flag;
    logic       gate_supply_fault_flag;
    logic [3:0] load_diag_done_report;
  } live_flags_t;

  typedef struct packed {
    logic [3:0] clip_flag;
    logic       clock_invalid_flag;
    logic [3:0] thermal_shutdown_flag;
    logic       thermal_shutdown_global;
    logic       battery_undervoltage_flag;
    logic       battery_overvoltage_flag;
    logic       stage_supply_undervoltage_flag;
    logic       stage_supply_overvoltage_flag;
    logic       logic_supply_por_flag;
    logic       gate_supply_fault_flag;
    logic [3:0] overtemp_warning_flag;
    logic       overtemp_warning_global;
    logic       gain_foldback_warning;
    logic [3:0] current_limit_warn_flag;
  } latched_flags_t;

  typedef logic [3:0][2:0] state_reports_t;
endpackage

// ==== sim/host_monitor.sv ====
// host side model counting fault and warning indication events
`timescale 1ns/1ps
module host_monitor (
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic       i_fault,
  input  wire logic       i_warn,
  output logic [7:0]      o_fault_cnt,
  output logic [7:0]      o_warn_cnt
);
  logic fault_reg;
  logic warn_reg;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      fault_reg   <= 1'b0;
      warn_reg    <= 1'b0;
      o_fault_cnt <= 8'h00;
      o_warn_cnt  <= 8'h00;
    end else begin
      fault_reg <= i_fault;
      warn_reg  <= i_warn;
      if (i_fault && !fault_reg) o_fault_cnt <= o_fault_cnt + 8'h01;
      if (i_warn && !warn_reg) o_warn_cnt <= o_warn_cnt + 8'h01;
    end
  end
endmodule

// ==== sim/fault_warn_signal_masking_tb.sv ====
// testbench for the fault and warning source masking block
`timescale 1ns/1ps
module fault_warn_signal_masking_tb;
  import sig_mask_pkg::*;
  logic           i_clk_sys = 1'b0;
  logic           i_nrst = 1'b0;
  logic           psel = 1'b0;
  logic           penable = 1'b0;
  logic           pwrite = 1'b0;
  logic [7:0]     paddr = 8'h00;
  logic [31:0]    pwdata = 32'h0000_0000;
  logic [3:0]     pstrb = 4'hf;
  logic           pready, perr, o_fault, o_warn, o_irq;
  logic [31:0]    prdata, rdat;
  logic [7:0]     fcnt, wcnt, ev;
  live_flags_t    lv = '0, nlv;
  latched_flags_t lt = '0, nlt;
  state_reports_t sr = '0, nsr;
  int             mismatches = 0;
  int             n_tests = 0;
  always #4 i_clk_sys = ~i_clk_sys;
  sig_mask #(.ADDR_W(8)) dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready), .o_pslverr(perr),
    .o_prdata(prdata), .i_live(lv), .i_latched(lt), .i_state_report(sr),
    .o_fault(o_fault), .o_warn(o_warn), .o_irq(o_irq));
  host_monitor host (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_fault(o_fault), .i_warn(o_warn), .o_fault_cnt(fcnt), .o_warn_cnt(wcnt));
  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx[5:0], 2'b00};
    pwdata <= d;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    do @(posedge i_clk_sys); while (pready !== 1'b1 && ++n < 50);
    rdat = prdata;
    chk("bus answer", 32'h0000_0001, {31'h0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task clr;
    nlv = '0;
    nlv.load_diag_done_report = 4'hf;
    nlt = '0;
    nsr = '0;
  endtask
  task t(input logic [7:0] fs, fm, wm, input logic ef, ew, input string nm);
    apb(1'b1, FAULT_STORED_IDX, {24'h0, fs});
    apb(1'b1, FAULT_LIVE_IDX, {24'h0, fm});
    apb(1'b1, WARN_STORED_IDX, {24'h0, wm});
    @(posedge i_clk_sys);
    lv <= nlv;
    lt <= nlt;
    sr <= nsr;
    repeat (2) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk({nm, " fault"}, {31'h0, ef}, {31'h0, o_fault});
    chk({nm, " warn"}, {31'h0, ew}, {31'h0, o_warn});
    $display("test %s done", nm);
  endtask
  initial begin
    #40000;
    mismatches++;
    summarize();
  end
  initial begin
    @(posedge i_clk_sys);
    lt.overtemp_warning_global <= 1'b1;
    @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    chk("reset warn", 32'h0000_0001, {31'h0, o_warn});
    apb(1'b0, WARN_STORED_IDX, 32'h0000_0000);
    chk("warn rst", 32'h0000_0004, rdat);
    apb(1'b0, FAULT_STORED_IDX, 32'h0000_0000);
    chk("stored rst", 32'h0000_0017, rdat);
    apb(1'b0, FAULT_LIVE_IDX, 32'h0000_0000);
    chk("live rst", 32'h0000_0000, rdat);
    apb(1'b1, FAULT_LIVE_IDX, 32'h0000_00ff);
    apb(1'b0, FAULT_LIVE_IDX, 32'h0000_0000);
    chk("live rsvd", 32'h0000_0079, rdat);
    apb(1'b1, WARN_STORED_IDX, 32'h0000_00ff);
    apb(1'b0, WARN_STORED_IDX, 32'h0000_0000);
    chk("warn rsvd", 32'h0000_007f, rdat);
    pstrb <= 4'he;
    apb(1'b1, WARN_STORED_IDX, 32'h0000_0000);
    pstrb <= 4'hf;
    chk("strobe err", 32'h0000_0000, {31'h0, perr});
    apb(1'b0, WARN_STORED_IDX, 32'h0000_0000);
    chk("warn strobe", 32'h0000_007f, rdat);
    apb(1'b0, 8'h3f, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rdat);
    chk("unmapped err", 32'h0000_0001, {31'h0, perr});
    $display("test registers done");
    clr;
    nlv.clock_invalid_flag = 1'b1;
    t(8'h00, 8'h20, 8'h00, 1'b1, 1'b0, "clkbad");
    clr;
    nlv.thermal_shutdown_flag = 4'h8;
    t(8'h00, 8'h10, 8'h00, 1'b1, 1'b0, "tsd");
    clr;
    nlv.gate_supply_fault_flag = 1'b1;
    t(8'h00, 8'h08, 8'h00, 1'b1, 1'b0, "supply");
    clr;
    nlv.load_diag_done_report = 4'he;
    t(8'h00, 8'h01, 8'h00, 1'b1, 1'b0, "diag");
    clr;
    t(8'h00, 8'h01, 8'h00, 1'b0, 1'b0, "diag done");
    nlt.clip_flag = 4'h4;
    t(8'h00, 8'h40, 8'h40, 1'b1, 1'b1, "clip");
    t(8'h00, 8'h00, 8'h40, 1'b0, 1'b1, "no chain");
    clr;
    nlt.clock_invalid_flag = 1'b1;
    t(8'h00, 8'h00, 8'h20, 1'b0, 1'b1, "lclk");
    clr;
    nlt.thermal_shutdown_flag = 4'h2;
    t(8'h00, 8'h00, 8'h10, 1'b0, 1'b1, "ltsd");
    clr;
    nlt.logic_supply_por_flag = 1'b1;
    t(8'h00, 8'h00, 8'h08, 1'b0, 1'b1, "lpor");
    clr;
    nlt.overtemp_warning_flag = 4'h1;
    t(8'h00, 8'h00, 8'h04, 1'b0, 1'b1, "otw");
    clr;
    nlt.gain_foldback_warning = 1'b1;
    t(8'h00, 8'h00, 8'h02, 1'b0, 1'b1, "fold");
    clr;
    nlt.current_limit_warn_flag = 4'h8;
    t(8'h00, 8'h40, 8'h01, 1'b1, 1'b1, "ilim");
    clr;
    nsr[2] = 3'h5;
    ev = fcnt;
    t(8'h40, 8'h00, 8'h00, 1'b1, 1'b0, "prot");
    chk("host fault", {24'h0, ev + 8'h01}, {24'h0, fcnt});
    nsr[2] = 3'h4;
    t(8'h40, 8'h00, 8'h00, 1'b0, 1'b0, "no prot");
    nlv = '1;
    nlt = '1;
    nsr = {4{3'h5}};
    t(8'h00, 8'h00, 8'h00, 1'b0, 1'b0, "none");
    t(8'h80, 8'h86, 8'h80, 1'b0, 1'b0, "reserved");
    t(8'h00, 8'h08, 8'h02, 1'b1, 1'b1, "or");
    apb(1'b1, IRQ_ENABLE_IDX, 32'h0000_0003);
    clr;
    t(8'h00, 8'h00, 8'h00, 1'b0, 1'b0, "idle");
    apb(1'b1, IRQ_CLEAR_IDX, 32'h0000_0003);
    @(posedge i_clk_sys);
    chk("irq idle", 32'h0000_0000, {31'h0, o_irq});
    ev = wcnt;
    nlt.current_limit_warn_flag = 4'h1;
    t(8'h00, 8'h00, 8'h01, 1'b0, 1'b1, "irq src");
    chk("irq set", 32'h0000_0001, {31'h0, o_irq});
    chk("host warn", {24'h0, ev + 8'h01}, {24'h0, wcnt});
    apb(1'b0, IRQ_STATUS_IDX, 32'h0000_0000);
    chk("irq status", 32'h0000_0002, rdat);
    apb(1'b1, IRQ_ENABLE_IDX, 32'h0000_0000);
    @(posedge i_clk_sys);
    chk("irq masked", 32'h0000_0000, {31'h0, o_irq});
    apb(1'b1, IRQ_CLEAR_IDX, 32'h0000_0002);
    apb(1'b0, IRQ_STATUS_IDX, 32'h0000_0000);
    chk("irq cleared", 32'h0000_0000, rdat);
    apb(1'b1, IRQ_STATUS_IDX, 32'h0000_0003);
    chk("status ro err", 32'h0000_0001, {31'h0, perr});
    apb(1'b0, IRQ_CLEAR_IDX, 32'h0000_0000);
    chk("clear wo err", 32'h0000_0001, {31'h0, perr});
    $display("test irq done");
    summarize();
  end
endmodule
